// [include/gfs_pkg.sv]
// gate fault supervisor: offsets, field positions, resets, types
// assumes a single AHB-Lite slave with 32-bit word registers
package gfs_pkg;
    // ==========================================
    // register byte addresses
    localparam logic [7:0] GFS_OFS_CTRL = 8'h00;
    localparam logic [7:0] GFS_OFS_CFG = 8'h04;
    localparam logic [7:0] GFS_OFS_DBLANK = 8'h08;
    localparam logic [7:0] GFS_OFS_OBLANK = 8'h0C;
    localparam logic [7:0] GFS_OFS_PLAT = 8'h10;
    localparam logic [7:0] GFS_OFS_STAT = 8'h14;
    localparam logic [7:0] GFS_OFS_ERR = 8'h18;
    localparam logic [7:0] GFS_OFS_ERRCLR = 8'h1C;
    localparam logic [7:0] GFS_OFS_ERREN = 8'h20;
    // ==========================================
    // field positions
    localparam int GFS_CTRL_CFGMODE = 0;
    localparam int GFS_CTRL_REACT = 1;
    localparam int GFS_CFG_DLVL = 0;
    localparam int GFS_CFG_CLAMP = 1;
    localparam int GFS_CFG_OLVL = 2;
    localparam int GFS_ERR_DESATURATION_SENSE = 0;
    localparam int GFS_ERR_OCP = 1;
    // ==========================================
    // reset values
    localparam logic [7:0] GFS_RST_DBLANK = 8'h10;
    localparam logic [7:0] GFS_RST_OBLANK = 8'h10;
    localparam logic [7:0] GFS_RST_PLAT = 8'h08;
    localparam logic [1:0] GFS_RST_ERREN = 2'h3;
    // ==========================================
    // types
    typedef struct packed {
        logic [1:0] ocp_lvl;
        logic clamp_en;
        logic desaturation_sense_lvl;
    } gfs_cfg_s;
    localparam gfs_cfg_s GFS_RST_CFG = '{2'h0, 1'b0, 1'b0};
    typedef enum logic [1:0] {
        GFS_OFF = 2'b00,
        GFS_ON = 2'b01,
        GFS_PLAT = 2'b10,
        GFS_HARD = 2'b11
    } gfs_state_e;
endpackage

// [logic/gfs_top.sv]
// gate fault supervisor: desaturation and overcurrent protection
// assumes comparator outputs and on command synchronous to MCLK
// Operation
// [R1] desaturation comparator is looked at only while the gate is on.
// [R2] at turn-on the desaturation_sense pin is pulled low for the desaturation_sense blanking count.
// [R3] desaturation_sense above threshold after blanking: safe off, flag, fault pin.
// [R4] desaturation_sense level select is writable only in configuration mode.
// [R5] live desaturation_sense comparator is readable apart from its sticky flag.
// [R6] at turn-off the desaturation_sense pin is pulled low for plateau plus blanking.
// [R7] with clamp enabled the desaturation_sense pin is clamped low while gate is off.
// [R8] overcurrent comparator is looked at only while the gate is on.
// [R9] at turn-on overcurrent evaluation waits the overcurrent blanking.
// [R10] overcurrent after blanking: safe off, flag, fault pin.
// [R11] live overcurrent comparator is readable, masked while blanking.
// [R12] overcurrent threshold follows the overcurrent level select field.
// [R13] after a fault the block stays disabled until a reactivate write.
// [R14] error flags stay set until software clears them.
`timescale 1ns/10ps
module gfs_top
    import gfs_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic MCLK, // clock 25 MHz
    input wire logic RST_B, // async reset, low
    input wire logic HSEL, // slave select
    input wire logic [31:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write when high
    input wire logic [2:0] HSIZE, // word only
    input wire logic [31:0] HWDATA, // write data
    input wire logic HREADY, // bus ready
    output logic [31:0] HRDATA, // read data
    output logic HREADYOUT, // low in reset, then always ready
    output logic HRESP, // always okay
    input wire logic PWM_ON_REQ, // requested on command
    input wire logic DESATURATION_SENSE_CMP, // desaturation_sense comparator
    input wire logic OCP_CMP, // overcurrent comparator
    output logic GATE_ON, // on command to stage
    output logic DESATURATION_SENSE_PULLDOWN, // force desaturation_sense pin low
    output logic DESATURATION_SENSE_CLAMP, // clamp desaturation_sense to ground
    output logic DESATURATION_SENSE_LEVEL_SEL, // alternate desaturation_sense level
    output logic [1:0] OCP_LEVEL_SEL, // overcurrent level
    output logic FAST_FAULT_N, // fast fault, low
    output logic IRQ // interrupt, high
);

    // ==========================================
    // bus address phase capture
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic bus_take;
    logic rd_take;
    logic wr_take;

    assign bus_take = HSEL && HTRANS[1] && HREADY;
    assign rd_take = bus_take && !HWRITE;
    assign wr_take = bus_take && HWRITE;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= HADDR[7:0];
        end
    end

    // data phase write to one offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_pend_r && (wr_addr_r == ofs);
    endfunction

    // counters stop at zero
    function automatic logic [CNT_W-1:0] cnt_dec(
        input logic [CNT_W-1:0] v
    );
        cnt_dec = (v == '0) ? v : v - 1'b1;
    endfunction

    // zero wait states, response always okay
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ==========================================
    // control and configuration registers
    logic cfg_mode_r;
    logic react_r;
    gfs_cfg_s cfg_r;
    logic [CNT_W-1:0] dblank_r;
    logic [CNT_W-1:0] oblank_r;
    logic [CNT_W-1:0] plat_r;
    logic [1:0] err_en_r;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_mode_r <= 1'b0;
            react_r <= 1'b0;
        end else begin
            react_r <= wr_hit(GFS_OFS_CTRL) && HWDATA[GFS_CTRL_REACT];
            if (wr_hit(GFS_OFS_CTRL)) begin
                cfg_mode_r <= HWDATA[GFS_CTRL_CFGMODE];
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_r <= GFS_RST_CFG;
        end else if (wr_hit(GFS_OFS_CFG)) begin
            if (cfg_mode_r) begin
                cfg_r.desaturation_sense_lvl <= HWDATA[GFS_CFG_DLVL] == 1'b1; // R4
            end
            cfg_r.clamp_en <= HWDATA[GFS_CFG_CLAMP];
            cfg_r.ocp_lvl <= HWDATA[GFS_CFG_OLVL +: 2];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            dblank_r <= CNT_W'(GFS_RST_DBLANK);
            oblank_r <= CNT_W'(GFS_RST_OBLANK);
            plat_r <= CNT_W'(GFS_RST_PLAT);
            err_en_r <= GFS_RST_ERREN;
        end else begin
            if (wr_hit(GFS_OFS_DBLANK)) begin
                dblank_r <= HWDATA[CNT_W-1:0];
            end
            if (wr_hit(GFS_OFS_OBLANK)) begin
                oblank_r <= HWDATA[CNT_W-1:0];
            end
            if (wr_hit(GFS_OFS_PLAT)) begin
                plat_r <= HWDATA[CNT_W-1:0];
            end
            if (wr_hit(GFS_OFS_ERREN)) begin
                err_en_r <= HWDATA[1:0];
            end
        end
    end

    // ==========================================
    // switching sequence
    gfs_state_e state_r;
    logic [CNT_W-1:0] dcnt_r;
    logic [CNT_W-1:0] ocnt_r;
    logic [CNT_W-1:0] tcnt_r;
    logic disabled_r;
    logic on_st;
    logic desaturation_sense_evt;
    logic ocp_evt;
    logic fault;
    logic turn_off;

    assign on_st = (state_r == GFS_ON);
    // comparators only count in on state after blanking
    assign desaturation_sense_evt = on_st && (dcnt_r == '0) && DESATURATION_SENSE_CMP; // R1 R3
    assign ocp_evt = on_st && (ocnt_r == '0) && OCP_CMP; // R8 R9 R10
    assign fault = desaturation_sense_evt || ocp_evt;
    assign turn_off = on_st && (fault || !PWM_ON_REQ);

    // operating state
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= GFS_OFF;
        end else begin
            case (state_r)
                GFS_OFF: begin
                    if (PWM_ON_REQ && !disabled_r) begin
                        state_r <= GFS_ON;
                    end
                end
                GFS_ON: begin
                    if (turn_off) begin
                        state_r <= GFS_PLAT;
                    end
                end
                GFS_PLAT: begin
                    if (tcnt_r == '0) begin
                        state_r <= GFS_HARD;
                    end
                end
                GFS_HARD: begin
                    if (tcnt_r == '0) begin
                        state_r <= GFS_OFF;
                    end
                end
                default: begin
                    state_r <= GFS_OFF;
                end
            endcase
        end
    end

    // blanking counters, reloaded in the off state, held in plateau and hard-off
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            dcnt_r <= '0;
            ocnt_r <= '0;
        end else if (state_r == GFS_OFF) begin
            dcnt_r <= dblank_r; // R2
            ocnt_r <= oblank_r; // R9
        end else if (on_st) begin
            dcnt_r <= cnt_dec(dcnt_r);
            ocnt_r <= cnt_dec(ocnt_r);
        end
    end

    // turn-off timer: plateau, then blanking extension
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            tcnt_r <= '0;
        end else begin
            case (state_r)
                GFS_ON: begin
                    tcnt_r <= plat_r; // R6
                end
                GFS_PLAT: begin
                    if (tcnt_r == '0) begin
                        tcnt_r <= dblank_r; // R6
                    end else begin
                        tcnt_r <= cnt_dec(tcnt_r);
                    end
                end
                default: begin
                    tcnt_r <= cnt_dec(tcnt_r);
                end
            endcase
        end
    end

    // ==========================================
    // disable latch and fast fault pin
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            disabled_r <= 1'b0;
            FAST_FAULT_N <= 1'b1;
        end else begin
            if (fault) begin
                disabled_r <= 1'b1; // R13
            end else if (react_r) begin
                disabled_r <= 1'b0; // R13
            end
            // pin falls only on the enabled-to-disabled change
            if (fault && !disabled_r) begin
                FAST_FAULT_N <= 1'b0; // R3 R10
            end else if (react_r) begin
                FAST_FAULT_N <= 1'b1;
            end
        end
    end

    // ==========================================
    // pin drive outputs
    logic gate_on_nxt;
    logic pull_nxt;

    assign gate_on_nxt = (state_r == GFS_OFF) ? PWM_ON_REQ && !disabled_r
        : (state_r == GFS_ON) && !fault && PWM_ON_REQ;
    assign pull_nxt = gate_on_nxt ?
        ((state_r == GFS_OFF) || (dcnt_r > 1)) : // R2
        (state_r == GFS_ON) || (state_r == GFS_PLAT) ||
        ((state_r == GFS_HARD) && (tcnt_r != '0)); // R6

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            GATE_ON <= 1'b0;
            DESATURATION_SENSE_PULLDOWN <= 1'b0;
            DESATURATION_SENSE_CLAMP <= 1'b0;
            DESATURATION_SENSE_LEVEL_SEL <= 1'b0;
            OCP_LEVEL_SEL <= 2'h0;
        end else begin
            GATE_ON <= gate_on_nxt;
            DESATURATION_SENSE_PULLDOWN <= pull_nxt;
            DESATURATION_SENSE_CLAMP <= cfg_r.clamp_en && !gate_on_nxt; // R7
            DESATURATION_SENSE_LEVEL_SEL <= cfg_r.desaturation_sense_lvl; // R4
            OCP_LEVEL_SEL <= cfg_r.ocp_lvl; // R12
        end
    end

    // ==========================================
    // sticky error flags and interrupt
    logic [1:0] err_r;
    logic [1:0] err_set;
    logic [1:0] err_clr;
    logic [1:0] err_nxt;

    assign err_set = {ocp_evt, desaturation_sense_evt};
    assign err_clr = wr_hit(GFS_OFS_ERRCLR) ? HWDATA[1:0] : 2'h0;
    // set wins over a clear in the same cycle
    assign err_nxt = (err_r & ~err_clr) | err_set;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            err_r <= 2'h0;
            IRQ <= 1'b0;
        end else begin
            err_r <= err_nxt; // R14
            IRQ <= |(err_nxt & err_en_r);
        end
    end

    // ==========================================
    // read data
    logic ocp_live;
    logic [31:0] rd_nxt;

    assign ocp_live = OCP_CMP && (state_r == GFS_ON)
        && (ocnt_r == '0); // R11

    // status is taken at the address edge
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (HADDR[7:0])
            GFS_OFS_CTRL: rd_nxt[GFS_CTRL_CFGMODE] = cfg_mode_r;
            GFS_OFS_CFG: rd_nxt[3:0] = cfg_r;
            GFS_OFS_DBLANK: rd_nxt[CNT_W-1:0] = dblank_r;
            GFS_OFS_OBLANK: rd_nxt[CNT_W-1:0] = oblank_r;
            GFS_OFS_PLAT: rd_nxt[CNT_W-1:0] = plat_r;
            GFS_OFS_STAT: rd_nxt[5:0] = {state_r, disabled_r,
                GATE_ON, ocp_live, DESATURATION_SENSE_CMP}; // R5 R11
            GFS_OFS_ERR: rd_nxt[1:0] = err_r; // R14
            GFS_OFS_ERREN: rd_nxt[1:0] = err_en_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_take) begin
            HRDATA <= rd_nxt;
        end
    end

endmodule

// [testbench/gfs_checker.sv]
// checker: protection relations at the supervisor pins
// assumes one clock domain, bound into gfs_top
`timescale 1ns/10ps
module gfs_checker (
    input wire logic MCLK, // clock
    input wire logic RST_B, // reset, low
    input wire logic GATE_ON, // on command
    input wire logic DESATURATION_SENSE_PULLDOWN, // pin forced low
    input wire logic DESATURATION_SENSE_CLAMP, // pin clamped
    input wire logic DESATURATION_SENSE_CMP, // desaturation_sense over
    input wire logic OCP_CMP, // ocp over
    input wire logic FAST_FAULT_N, // fault, low
    input wire logic IRQ // interrupt
);
    // ==========
    // desaturation_sense trip steps
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    sequence s_hit;
        GATE_ON && !DESATURATION_SENSE_PULLDOWN && DESATURATION_SENSE_CMP;
    endsequence
    sequence s_safe_off;
        !GATE_ON && DESATURATION_SENSE_PULLDOWN;
    endsequence
    // ==========
    // assertions
    AST_DESATURATION_SENSE_TRIP: assert property (s_hit |=> s_safe_off)
        else $error("desaturation_sense trip missed");
    AST_DESATURATION_SENSE_PIN: assert property (GATE_ON && !DESATURATION_SENSE_PULLDOWN
        && DESATURATION_SENSE_CMP && FAST_FAULT_N |=> !FAST_FAULT_N)
        else $error("fault pin missed");
    AST_OFF_IGNORE: assert property ($fell(FAST_FAULT_N)
        |-> $past(GATE_ON))
        else $error("fault while off");
    AST_BLANK_PULL: assert property ($rose(GATE_ON) |-> DESATURATION_SENSE_PULLDOWN)
        else $error("no blanking pull");
    AST_CLAMP_OFF: assert property (DESATURATION_SENSE_CLAMP |-> !GATE_ON)
        else $error("clamp while on");
    AST_OCP_TRIP: assert property ($rose(GATE_ON && OCP_CMP)
        |-> ##[1:300] !GATE_ON)
        else $error("ocp trip missed");
    AST_STAY_OFF: assert property (!FAST_FAULT_N |-> !GATE_ON)
        else $error("on while disabled");
    AST_FLAG_IRQ: assert property ($fell(FAST_FAULT_N) |-> ##[1:2] IRQ)
        else $error("flag irq missed");
endmodule
bind gfs_top gfs_checker i_gfs_checker (.MCLK, .RST_B, .GATE_ON,
    .DESATURATION_SENSE_PULLDOWN, .DESATURATION_SENSE_CLAMP, .DESATURATION_SENSE_CMP, .OCP_CMP, .FAST_FAULT_N,
    .IRQ);

// [testbench/gfs_switch_model.sv]
// model of the power switch and its sense circuits
// assumes pin forcing and clamp come straight from the supervisor
`timescale 1ns/10ps
module gfs_switch_model (
    input wire logic pull_low, // pin forced low
    input wire logic clamp, // pin clamped to ground
    input wire logic short_desaturation_sense, // switch out of saturation
    input wire logic over_current, // sense resistor over level
    output logic desaturation_sense_cmp, // desaturation_sense over level
    output logic ocp_cmp // ocp over level
);
    // ==========
    // comparators
    // pull-up lifts the pin whenever it is not held low
    assign desaturation_sense_cmp = short_desaturation_sense & ~pull_low & ~clamp;
    // ocp comparator follows the over_current input directly
    assign ocp_cmp = over_current;
endmodule

// [testbench/tb_gfs_top.sv]
// testbench: register tasks over AHB-Lite and protection scenarios
// assumes gfs_top is the only slave and the checker is bound
`timescale 1ns/10ps
module tb_gfs_top;
    import gfs_pkg::*;
    logic MCLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, HREADY;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
    logic [1:0] HTRANS = 0, OCP_LEVEL_SEL;
    logic PWM_ON_REQ = 0, DESATURATION_SENSE_CMP, OCP_CMP, GATE_ON, DESATURATION_SENSE_PULLDOWN;
    logic DESATURATION_SENSE_CLAMP, DESATURATION_SENSE_LEVEL_SEL, FAST_FAULT_N, IRQ, HREADYOUT, HRESP;
    logic short_desaturation_sense = 0, over_cur = 0;
    int miscompares = 0, cmp_count = 0, n;
    assign HREADY = HREADYOUT;
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    gfs_top i_gfs_top (.MCLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE(3'b010), .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
        .PWM_ON_REQ, .DESATURATION_SENSE_CMP, .OCP_CMP, .GATE_ON, .DESATURATION_SENSE_PULLDOWN,
        .DESATURATION_SENSE_CLAMP, .DESATURATION_SENSE_LEVEL_SEL, .OCP_LEVEL_SEL, .FAST_FAULT_N,
        .IRQ);
    gfs_switch_model i_gfs_switch_model (.pull_low(DESATURATION_SENSE_PULLDOWN),
        .clamp(DESATURATION_SENSE_CLAMP), .short_desaturation_sense(short_desaturation_sense),
        .over_current(over_cur), .desaturation_sense_cmp(DESATURATION_SENSE_CMP), .ocp_cmp(OCP_CMP));
    // ==========
    // tasks
    task check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= wr;
        HADDR <= 32'(a);
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        check("hresp", 32'(HRESP), 32'h0000_0000);
    endtask
    task chk_rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        check($sformatf("reg %h", a), rd, e);
    endtask
    task settle;
        repeat (3) @(negedge MCLK);
    endtask
    task drive(input logic req, sd, oc);
        @(posedge MCLK);
        PWM_ON_REQ <= req;
        short_desaturation_sense <= sd;
        over_cur <= oc;
    endtask
    // cycles that gate or pulldown stays high
    task span(input logic pd, output int k);
        k = 0;
        while (k < 400 && (pd ? DESATURATION_SENSE_PULLDOWN : GATE_ON) === 1'b1) begin
            @(negedge MCLK);
            k++;
        end
    endtask
    task wait_on;
        n = 0;
        while (GATE_ON !== 1'b1 && n < 50) begin
            @(negedge MCLK);
            n++;
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        miscompares++;
        test_done;
    end
    // ==========
    // scenarios
    initial begin
        repeat (10) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (2) @(posedge MCLK);
        chk_rd(GFS_OFS_DBLANK, 32'h0000_0010);
        chk_rd(GFS_OFS_OBLANK, 32'h0000_0010);
        chk_rd(GFS_OFS_PLAT, 32'h0000_0008);
        chk_rd(GFS_OFS_ERREN, 32'h0000_0003);
        chk_rd(8'h24, 32'h0000_0000);
        xfer(1'b1, GFS_OFS_CFG, 32'h0000_0001);
        chk_rd(GFS_OFS_CFG, 32'h0000_0000);
        xfer(1'b1, GFS_OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, GFS_OFS_CFG, 32'(i * 4 + 1));
            settle;
            check("ocp_lvl", 32'(OCP_LEVEL_SEL), 32'(i));
        end
        check("desaturation_sense_lvl", 32'(DESATURATION_SENSE_LEVEL_SEL), 32'h0000_0001);
        xfer(1'b1, GFS_OFS_CTRL, 32'h0000_0000);
        xfer(1'b1, GFS_OFS_CFG, 32'h0000_0000);
        chk_rd(GFS_OFS_CFG, 32'h0000_0001);
        // comparators over while the gate is off
        drive(1'b0, 1'b1, 1'b1);
        settle;
        chk_rd(GFS_OFS_STAT, 32'h0000_0001);
        chk_rd(GFS_OFS_ERR, 32'h0000_0000);
        xfer(1'b1, GFS_OFS_DBLANK, 32'h0000_0005);
        xfer(1'b1, GFS_OFS_PLAT, 32'h0000_0003);
        drive(1'b1, 1'b1, 1'b0);
        wait_on;
        span(1'b0, n);
        check("desaturation_sense_on", 32'(n >= 5 && n <= 8), 32'h0000_0001);
        span(1'b1, n);
        check("off_pull", 32'(n), 32'(3 + 5 + 2));
        check("fault_n", 32'(FAST_FAULT_N), 32'h0000_0000);
        chk_rd(GFS_OFS_ERR, 32'h0000_0001);
        drive(1'b0, 1'b0, 1'b0);
        drive(1'b1, 1'b0, 1'b0);
        settle;
        check("gate", 32'(GATE_ON), 32'h0000_0000);
        drive(1'b0, 1'b0, 1'b0);
        check("irq", 32'(IRQ), 32'h0000_0001);
        xfer(1'b1, GFS_OFS_ERREN, 32'h0000_0000);
        settle;
        check("irq", 32'(IRQ), 32'h0000_0000);
        xfer(1'b1, GFS_OFS_ERREN, 32'h0000_0003);
        settle;
        check("irq", 32'(IRQ), 32'h0000_0001);
        xfer(1'b1, GFS_OFS_CTRL, 32'h0000_0002);
        settle;
        check("fault_n", 32'(FAST_FAULT_N), 32'h0000_0001);
        chk_rd(GFS_OFS_ERR, 32'h0000_0001);
        xfer(1'b1, GFS_OFS_ERRCLR, 32'h0000_0001);
        chk_rd(GFS_OFS_ERR, 32'h0000_0000);
        check("irq", 32'(IRQ), 32'h0000_0000);
        // overcurrent present from turn-on, longer blanking
        xfer(1'b1, GFS_OFS_OBLANK, 32'h0000_0014);
        drive(1'b1, 1'b0, 1'b1);
        wait_on;
        repeat (8) @(negedge MCLK);
        chk_rd(GFS_OFS_STAT, 32'h0000_0014);
        span(1'b0, n);
        chk_rd(GFS_OFS_ERR, 32'h0000_0002);
        check("fault_n", 32'(FAST_FAULT_N), 32'h0000_0000);
        drive(1'b0, 1'b0, 1'b0);
        xfer(1'b1, GFS_OFS_CTRL, 32'h0000_0002);
        xfer(1'b1, GFS_OFS_ERRCLR, 32'h0000_0003);
        // clamp while off, released while on
        xfer(1'b1, GFS_OFS_CFG, 32'h0000_0002);
        settle;
        check("clamp", 32'(DESATURATION_SENSE_CLAMP), 32'h0000_0001);
        drive(1'b1, 1'b0, 1'b0);
        wait_on;
        check("clamp", 32'(DESATURATION_SENSE_CLAMP), 32'h0000_0000);
        drive(1'b0, 1'b0, 1'b0);
        repeat (30) @(negedge MCLK);
        check("clamp", 32'(DESATURATION_SENSE_CLAMP), 32'h0000_0001);
        check("fault_n", 32'(FAST_FAULT_N), 32'h0000_0001);
        test_done;
    end
endmodule
